// ==== common/muxbus_pkg.sv ====
/*
 * Shared constants for the multiplexed address/data bus: widths, burst
 * length, byte-lane field positions, decoder layout and FIFO sizing.
 * Assumes both bus ends and the bench compile it first.
 */
package muxbus_pkg;
	localparam int BUS_W        = 32;
	localparam int BURST_WORDS  = 4;
	localparam int IDX_W        = 2;
	localparam int LANE_LSB     = 0;
	localparam int LANE_W       = 4;
	localparam int DIAG_W       = 2;
	localparam int WORD_LSB     = 4;
	localparam int CS_LSB       = 28;
	localparam int CS_W         = 4;
	localparam int FIFO_DEPTH   = 16;
	localparam logic [3:0] LANES_NONE_N = 4'hf;
	localparam logic [1:0] DIAG_UNCACHED = 2'h0;
	localparam logic [1:0] DIAG_IFETCH   = 2'h2;
	localparam logic [1:0] DIAG_DFETCH   = 2'h3;
	localparam int MEM_WAIT     = 1;
endpackage

// ==== common/muxbus_if.sv ====
/*
 * Wires between the bus master end and the memory end. The shared
 * address/data lines are resolved here from the two enables.
 * Assumes one clock, bus_clock, driven by the bench.
 */
`timescale 1ns/10ps
interface muxbus_if (
	input wire logic bus_clock
);
	logic [31:0] ad_out_m;
	logic        ad_oe_m;
	logic [31:0] ad_out_s;
	logic        ad_oe_s;
	logic [31:0] ad;
	logic        addr_latch_strobe;
	logic        rd_n;
	logic        wr_n;
	logic        burst;
	logic [1:0]  word_index;
	logic [1:0]  diag;
	logic        read_word_strobe;
	logic        ack;

	// Bus level: whoever enables drives, otherwise pulled low
	assign ad = ad_oe_m ? ad_out_m : (ad_oe_s ? ad_out_s : 32'h0);

	modport master (
		input  bus_clock, ad, read_word_strobe, ack,
		output ad_out_m, ad_oe_m, addr_latch_strobe, rd_n, wr_n, burst, word_index, diag
	);
	modport memory (
		input  bus_clock, ad, addr_latch_strobe, rd_n, wr_n, burst, word_index, diag,
		output ad_out_s, ad_oe_s, read_word_strobe, ack
	);
endinterface

// ==== verilog/muxbus_fifo.sv ====
/*
 * Parameterised synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
module muxbus_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             REF_CLK,
	input  wire logic             RST_N,
	// Fill side
	input  wire logic             IN_VALID,
	output logic                  IN_READY,
	input  wire logic [WIDTH-1:0] IN_DATA,
	// Drain side
	output logic                  OUT_VALID,
	input  wire logic             OUT_READY,
	output logic [WIDTH-1:0]      OUT_DATA
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Honest flags straight from the occupancy count
	assign IN_READY  = (cnt_q != (AW+1)'(DEPTH));
	assign OUT_VALID = (cnt_q != '0);
	assign OUT_DATA  = mem[rp_q];
	assign push      = IN_VALID && IN_READY;
	assign pop       = OUT_VALID && OUT_READY;

	// Storage has no reset; only pointers and count need defined values
	always_ff @(posedge REF_CLK) begin
		if (push) begin
			mem[wp_q] <= IN_DATA;
		end
	end

	// Pointers and count
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // muxbus_fifo

// ==== verilog/muxbus_master.sv ====
/*
 * Processor end of the multiplexed bus: drives address with byte-lane
 * selects, strobes, burst and word index; buffers writes in a 16-word
 * FIFO; captures read words on each read strobe into a 4-deep buffer.
 * Assumes the memory end keeps its handshake rules on the same clock.
 *
 */
`timescale 1ns/10ps
module muxbus_master (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	// Core write request
	input  wire logic        WR_VALID,
	output logic             WR_READY,
	input  wire logic [29:0] WR_WORD_ADDR,
	input  wire logic [3:0]  WR_LANES_N,
	input  wire logic [31:0] WR_DATA,
	// Core read request
	input  wire logic        RD_VALID,
	output logic             RD_READY,
	input  wire logic [29:0] RD_WORD_ADDR,
	input  wire logic [3:0]  RD_LANES_N,
	input  wire logic        RD_BURST,
	input  wire logic [1:0]  RD_DIAG,
	// Core read answer
	output logic [127:0]     RD_WORDS,
	output logic             RD_DONE,
	output logic             CORE_RESUME,
	// Bus side
	muxbus_if.master         bus
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b011,
		ST_END   = 3'b100
	} state_t;

	state_t       st_q;
	logic         is_wr_q;
	logic         burst_q;
	logic [29:0]  waddr_q;
	logic [3:0]   lanes_q;
	logic [1:0]   diag_q;
	logic [31:0]  wdata_q;
	logic [1:0]   idx_q;
	logic [1:0]   got_q;
	logic [31:0]  rbuf_q [muxbus_pkg::BURST_WORDS];
	logic         done_q;
	logic         resume_q;
	logic         f_valid;
	logic         f_ready;
	logic [65:0]  f_data;

	////////////////////////////////////////////////////////////////////////
	// Write buffer: core writes at its own pace, FIFO back-pressures it
	muxbus_fifo #(
		.WIDTH (66),
		.DEPTH (muxbus_pkg::FIFO_DEPTH)
	) u_wbuf (
		.REF_CLK   (REF_CLK),
		.RST_N     (RST_N),
		.IN_VALID  (WR_VALID),
		.IN_READY  (WR_READY),
		.IN_DATA   ({WR_WORD_ADDR, WR_LANES_N, WR_DATA}),
		.OUT_VALID (f_valid),
		.OUT_READY (f_ready),
		.OUT_DATA  (f_data)
	);

	// Writes drain first; a pending read waits, which keeps ordering simple
	assign f_ready  = (st_q == ST_IDLE);
	assign RD_READY = (st_q == ST_IDLE) && !f_valid;

	////////////////////////////////////////////////////////////////////////
	// Cycle sequencer
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (f_valid || RD_VALID) begin
						st_q <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					// One full cycle of address phase covers the latch hold
					st_q <= is_wr_q ? ST_WRITE : ST_READ;
				end
				ST_READ: begin
					if (bus.read_word_strobe && (!burst_q || got_q == 2'h3)) begin
						st_q <= ST_END;
					end
				end
				ST_WRITE: begin
					if (bus.ack) begin
						st_q <= ST_END;
					end
				end
				ST_END: begin
					st_q <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Request capture at cycle start
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			is_wr_q <= 1'b0;
			burst_q <= 1'b0;
			waddr_q <= '0;
			lanes_q <= muxbus_pkg::LANES_NONE_N;
			diag_q  <= muxbus_pkg::DIAG_UNCACHED;
			wdata_q <= '0;
		end else if (st_q == ST_IDLE && f_valid) begin
			is_wr_q <= 1'b1;
			burst_q <= 1'b0;
			waddr_q <= f_data[65:36];
			lanes_q <= f_data[35:32];
			wdata_q <= f_data[31:0];
			diag_q  <= muxbus_pkg::DIAG_UNCACHED;
		end else if (st_q == ST_IDLE && RD_VALID) begin
			is_wr_q <= 1'b0;
			burst_q <= RD_BURST;
			waddr_q <= RD_WORD_ADDR;
			lanes_q <= RD_BURST ? 4'h0 : RD_LANES_N;
			diag_q  <= RD_DIAG;
		end
	end

	// Word index: miss address for singles and writes, counts on bursts
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			idx_q <= '0;
			got_q <= '0;
		end else if (st_q == ST_IDLE) begin
			idx_q <= (!f_valid && RD_VALID && RD_BURST) ? 2'h0 :
			         (f_valid ? f_data[37:36] : RD_WORD_ADDR[1:0]);
			got_q <= '0;
		end else if (st_q == ST_READ && bus.read_word_strobe && burst_q) begin
			idx_q <= idx_q + 2'h1;
			got_q <= got_q + 2'h1;
		end
	end

	// Read buffer loads on each word strobe
	always_ff @(posedge REF_CLK) begin
		if (st_q == ST_READ && bus.read_word_strobe) begin
			rbuf_q[got_q] <= bus.ad;
		end
	end

	// Only requested lanes reach the core; others read as zero
	genvar gi, gb;
	generate
		for (gi = 0; gi < muxbus_pkg::BURST_WORDS; gi++) begin : g_out
			for (gb = 0; gb < 4; gb++) begin : g_lane
				// Constant slices keep every lane its own single driver
				assign RD_WORDS[gi*32 + gb*8 +: 8] = lanes_q[gb] ? 8'h00 : rbuf_q[gi][gb*8 +: 8];
			end
		end
	endgenerate

	// Completion and resume pulses
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			done_q   <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			done_q   <= (st_q == ST_READ) && bus.read_word_strobe && (!burst_q || got_q == 2'h3);
			resume_q <= (st_q == ST_READ) && bus.ack && !resume_q;
		end
	end
	assign RD_DONE     = done_q;
	assign CORE_RESUME = resume_q || (done_q && !burst_q);

	////////////////////////////////////////////////////////////////////////
	// Bus pins
	assign bus.addr_latch_strobe = (st_q == ST_ADDR);
	assign bus.ad_oe_m    = (st_q == ST_ADDR) || (st_q == ST_WRITE);
	assign bus.ad_out_m   = (st_q == ST_ADDR) ? {waddr_q[29:2], lanes_q} : wdata_q;
	assign bus.rd_n       = !((st_q == ST_ADDR || st_q == ST_READ) && !is_wr_q);
	assign bus.wr_n       = !((st_q == ST_ADDR || st_q == ST_WRITE) && is_wr_q);
	assign bus.burst      = burst_q && (st_q != ST_IDLE);
	assign bus.word_index = idx_q;
	assign bus.diag       = diag_q;
endmodule // muxbus_master

// ==== verilog/muxbus_memory.sv ====
/*
 * Memory end: latches address and byte-lane selects, decodes a chip
 * select registered on cycle begin, answers reads with read strobes and
 * writes with acknowledge, writing only selected lanes.
 * Assumes the master end on the same clock.
 */
`timescale 1ns/10ps
module muxbus_memory #(
	parameter int MEM_WORDS = 256
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	// User side
	output logic [3:0]       CHIP_SEL,
	output logic [1:0]       FETCH_KIND,
	output logic [31:0]      LATCHED_ADDR,
	// Bus side
	muxbus_if.memory         bus
);
	localparam int AW = $clog2(MEM_WORDS);
	logic [31:0] lat_q;
	logic [1:0]  diag_q;
	logic [3:0]  cs_q;
	logic [31:0] mem [MEM_WORDS];
	logic        rd_prev_q;
	logic        wr_prev_q;
	logic        cycle_begin;
	logic [1:0]  wait_q;
	logic        strobe_q;
	logic        ack_q;
	logic [AW-1:0] widx;

	// Latch follows the bus while strobe high, holds after
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			lat_q  <= '0;
			diag_q <= '0;
		end else if (bus.addr_latch_strobe) begin
			lat_q  <= bus.ad;
			diag_q <= bus.diag;
		end
	end

	// Cycle begin from falling read or write strobe
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
		end else begin
			rd_prev_q <= bus.rd_n;
			wr_prev_q <= bus.wr_n;
		end
	end
	assign cycle_begin = (rd_prev_q && !bus.rd_n) || (wr_prev_q && !bus.wr_n);

	// Registered decode avoids glitches; idle means no select
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			cs_q <= '0;
		end else if (bus.rd_n && bus.wr_n) begin
			cs_q <= '0;
		end else if (cycle_begin) begin
			cs_q <= 4'h1 << bus.ad[muxbus_pkg::CS_LSB +: 2];
		end
	end

	assign widx = AW'({lat_q[31:muxbus_pkg::WORD_LSB], bus.word_index});

	// Wait counter then one strobe per word or one acknowledge
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			wait_q   <= '0;
			strobe_q <= 1'b0;
			ack_q    <= 1'b0;
		end else begin
			strobe_q <= 1'b0;
			ack_q    <= 1'b0;
			if ((bus.rd_n && bus.wr_n) || cycle_begin || strobe_q || ack_q) begin
				wait_q <= '0;
			end else if (wait_q != 2'(muxbus_pkg::MEM_WAIT)) begin
				wait_q <= wait_q + 2'h1;
			end else if (!bus.rd_n) begin
				strobe_q <= 1'b1;
				ack_q    <= bus.burst && bus.word_index == 2'h3;
			end else begin
				ack_q    <= 1'b1;
			end
		end
	end

	// Write only the lanes whose selects are low
	always_ff @(posedge REF_CLK) begin
		if (!bus.wr_n && wait_q == 2'(muxbus_pkg::MEM_WAIT) && !ack_q) begin
			for (int b = 0; b < 4; b++) begin
				if (!lat_q[b]) begin
					mem[widx][b*8 +: 8] <= bus.ad[b*8 +: 8];
				end
			end
		end
	end

	// Full word returned on reads regardless of lanes
	assign bus.ad_out_s         = mem[widx];
	assign bus.ad_oe_s          = strobe_q;
	assign bus.read_word_strobe = strobe_q;
	assign bus.ack              = ack_q;
	assign CHIP_SEL             = cs_q;
	assign FETCH_KIND           = diag_q;
	assign LATCHED_ADDR         = lat_q;
endmodule // muxbus_memory

// ==== verif/muxbus_chk.sv ====
/*
 * Protocol checker for the muxed address/data bus between the two ends.
 * Assumes the bench wires it to the interface signals and bench reset.
 */
`timescale 1ns/10ps
module muxbus_chk (
	// Clock and reset
	input wire logic       bus_clock,
	input wire logic       RST_N,
	// Bus wires
	input wire logic       ad_oe_m,
	input wire logic       ad_oe_s,
	input wire logic       addr_latch_strobe,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic       burst,
	input wire logic [1:0] word_index,
	input wire logic       read_word_strobe,
	input wire logic       ack
);
	default clocking cb @(posedge bus_clock); endclocking
	default disable iff (!RST_N);

	logic [2:0] words_q;
	logic       burst_q;

	////////////////////////////////////////////////////////////////////////
	// Count read words from the address phase; kind kept for the end check
	always_ff @(posedge bus_clock) begin
		if (!RST_N || addr_latch_strobe) begin
			words_q <= 3'h0;
			burst_q <= burst && !rd_n && RST_N;
		end else if (read_word_strobe) begin
			words_q <= words_q + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus rules
	strobe_pulse_a: assert property (addr_latch_strobe |=> !addr_latch_strobe)
		else $error("address strobe longer than one cycle");
	addr_phase_a: assert property (addr_latch_strobe |-> (rd_n != wr_n) && ad_oe_m && !ad_oe_s)
		else $error("address phase without master drive");
	no_clash_a: assert property (!(ad_oe_m && ad_oe_s))
		else $error("both ends drive the bus");
	burst_start_a: assert property (addr_latch_strobe && burst && !rd_n |-> word_index == 2'h0)
		else $error("burst does not start at word zero");
	burst_step_a: assert property (read_word_strobe && burst && word_index != 2'h3 |=>
		word_index == $past(word_index) + 2'h1) else $error("word index did not step");
	index_hold_a: assert property ((!rd_n || !wr_n) && $past(!rd_n || !wr_n) && !$past(read_word_strobe)
		|-> $stable(word_index)) else $error("word index moved inside cycle");
	burst_words_a: assert property ($rose(rd_n) && burst_q |-> words_q == 3'h4)
		else $error("burst did not carry four words");
	single_word_a: assert property ($rose(rd_n) && !burst_q |-> words_q == 3'h1)
		else $error("single read did not carry one word");
	strobe_read_a: assert property (read_word_strobe |-> !rd_n && ad_oe_s && !ad_oe_m)
		else $error("read strobe outside read data phase");
	write_ack_a: assert property ($fell(wr_n) |-> ##[1:8] ack)
		else $error("write never acknowledged");

	// Main scenarios seen
	burst_cov: cover property ($rose(rd_n) && burst_q);
	single_cov: cover property ($rose(rd_n) && !burst_q);
	write_cov: cover property (ack && !wr_n);
endmodule // muxbus_chk

// ==== verif/testbench.sv ====
/*
 * Bench joining both bus ends: writes, bursts, single reads, buffer fill.
 * Assumes memory words index by the low word-address bits.
 */
`timescale 1ns/10ps
module testbench;
	typedef struct {logic [127:0] w; logic [127:0] m; logic [1:0] dg; logic [3:0] cs; logic b; logic [31:0] la;} exp_t;

	logic         ref_clk, rst_n, wr_valid, rd_valid, rd_burst;
	logic         wr_ready, rd_ready, rd_done, core_resume;
	logic [29:0]  wr_addr, rd_addr, a;
	logic [3:0]   wr_lanes_n, rd_lanes_n, chip_sel, cs_seen;
	logic [31:0]  wr_data, latched_addr;
	logic [1:0]   rd_diag, fetch_kind;
	logic [127:0] rd_words;
	logic [1:0]   dgs [4] = '{2'h0, 2'h2, 2'h3, 2'h2};
	logic [31:0]  mdl [logic [29:0]];
	int           mismatches, samples_checked, resumes, refusals, k;
	exp_t         expq [$];
	exp_t         e;

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	muxbus_if bus_if (.bus_clock(ref_clk));
	muxbus_master u_muxbus_master (.REF_CLK(ref_clk), .RST_N(rst_n), .WR_VALID(wr_valid), .WR_READY(wr_ready),
		.WR_WORD_ADDR(wr_addr), .WR_LANES_N(wr_lanes_n), .WR_DATA(wr_data), .RD_VALID(rd_valid),
		.RD_READY(rd_ready), .RD_WORD_ADDR(rd_addr), .RD_LANES_N(rd_lanes_n), .RD_BURST(rd_burst),
		.RD_DIAG(rd_diag), .RD_WORDS(rd_words), .RD_DONE(rd_done), .CORE_RESUME(core_resume), .bus(bus_if));
	muxbus_memory u_muxbus_memory (.REF_CLK(ref_clk), .RST_N(rst_n), .CHIP_SEL(chip_sel),
		.FETCH_KIND(fetch_kind), .LATCHED_ADDR(latched_addr), .bus(bus_if));
	muxbus_chk u_muxbus_chk (.bus_clock(ref_clk), .RST_N(rst_n), .ad_oe_m(bus_if.ad_oe_m),
		.ad_oe_s(bus_if.ad_oe_s), .addr_latch_strobe(bus_if.addr_latch_strobe), .rd_n(bus_if.rd_n),
		.wr_n(bus_if.wr_n), .burst(bus_if.burst), .word_index(bus_if.word_index),
		.read_word_strobe(bus_if.read_word_strobe), .ack(bus_if.ack));

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic fail(input string s);
		$display("wrong value at %0t: %s", $time, s);
		mismatches++;
	endtask

	task automatic chk_words(input logic [127:0] got, input logic [127:0] exp, input string s);
		samples_checked++;
		if (got !== exp) fail(s);
	endtask

	task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp, input string s);
		samples_checked++;
		if (got !== exp) fail(s);
	endtask

	function automatic logic [31:0] lmask(input logic [3:0] ln);
		return {{8{!ln[3]}}, {8{!ln[2]}}, {8{!ln[1]}}, {8{!ln[0]}}};
	endfunction

	// Ready is read at the falling edge so the taking edge is never raced
	task automatic await(input logic sel);
		int  n;
		logic ok;
		n = 0;
		do begin
			@(negedge ref_clk);
			ok = sel ? wr_ready : rd_ready;
			if (ok !== 1'b1) refusals++;
			@(posedge ref_clk);
			n++;
		end while (ok !== 1'b1 && n < 500);
		if (ok !== 1'b1) begin
			fail("handshake timeout");
			finish_test();
		end
	endtask

	// Valid stays up between calls so no signal is assigned twice per step
	task automatic wr(input logic [29:0] wa, input logic [3:0] ln, input logic [31:0] d);
		rd_valid <= 1'b0;
		wr_valid <= 1'b1;
		wr_addr <= wa;
		wr_lanes_n <= ln;
		wr_data <= d;
		await(1'b1);
		mdl[wa] = ((mdl.exists(wa) ? mdl[wa] : 32'h0) & ~lmask(ln)) | (d & lmask(ln));
	endtask

	task automatic rd(input logic [29:0] ra, input logic [3:0] ln, input logic b, input logic [1:0] dg);
		exp_t x;
		wr_valid <= 1'b0;
		rd_valid <= 1'b1;
		rd_addr <= ra;
		rd_lanes_n <= ln;
		rd_burst <= b;
		rd_diag <= dg;
		await(1'b0);
		x.w = 128'h0;
		x.m = 128'h0;
		for (int i = 0; i < (b ? 4 : 1); i++) begin
			x.w[32*i +: 32] = mdl[b ? {ra[29:2], 2'(i)} : ra] & lmask(ln);
			x.m[32*i +: 32] = 32'hffffffff;
		end
		x.dg = dg;
		x.cs = 4'h1 << ra[27:26];
		x.b = b;
		x.la = {ra[29:2], b ? 4'h0 : ln};
		expq.push_back(x);
	endtask

	task automatic drain();
		int n;
		wr_valid <= 1'b0;
		rd_valid <= 1'b0;
		n = 0;
		while (expq.size() != 0 && n < 500) begin
			@(posedge ref_clk);
			n++;
		end
		if (expq.size() != 0) begin
			fail("read never finished");
			finish_test();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Result watcher: chip select caught at a word strobe, all else at done;
	// sampled mid-cycle so no output is read in the edge that launches it
	always @(negedge ref_clk) begin
		if (bus_if.read_word_strobe === 1'b1) cs_seen = chip_sel;
		if (core_resume === 1'b1) resumes++;
		if (rd_done === 1'b1) begin
			if (expq.size() == 0) begin
				fail("unexpected read done");
			end else begin
				e = expq.pop_front();
				chk_words(rd_words & e.m, e.w, "read words");
				chk_bits(fetch_kind, e.dg, "fetch kind");
				chk_bits(cs_seen, e.cs, "chip select");
				chk_bits(latched_addr, e.la, "latched address");
				if (e.b) chk_bits(resumes, 1, "core resume");
				resumes = 0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{mismatches, samples_checked, resumes, refusals} = '0;
		{wr_valid, rd_valid, rd_burst, rst_n} = 4'h0;
		{wr_addr, rd_addr, wr_lanes_n, rd_lanes_n, wr_data, rd_diag} = 102'h0;
		void'($urandom(30171));
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk_bits(chip_sel, 4'h0, "chip select while idle");
		for (k = 0; k < 4; k++) wr(30'h40 + 30'(k), 4'h0, $urandom);
		wr(30'h41, 4'hc, $urandom);
		rd(30'h42, 4'h0, 1'b1, 2'h3);
		rd(30'h40, 4'h0, 1'b1, 2'h2);
		for (k = 0; k < 4; k++) begin
			a = {2'h0, 2'(k), 18'h0, 8'h50 + 8'(k)};
			// Fresh words are filled whole first, so no lane reads back unknown
			wr(a, 4'h0, $urandom);
			wr(a, 4'($urandom), $urandom);
			rd(a, 4'($urandom), 1'b0, dgs[k]);
		end
		refusals = 0;
		// One write retires per six cycles, so 24 back to back overflow 16 words
		for (k = 0; k < 24; k++) wr(30'h20 + 30'(k), 4'h0, $urandom);
		chk_bits(32'(refusals != 0), 1, "write buffer never full");
		refusals = 0;
		rd(30'h31, 4'h0, 1'b0, 2'h0);
		chk_bits(32'(refusals != 0), 1, "read not held behind writes");
		drain();
		finish_test();
	end
endmodule // testbench
